// ===== logic/pdc_map.svh
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// number of port 2 wake pins
`define PDC_P2_W 16
// reset value of the wake-source select
`define PDC_CFG_RST 1'b0
// reset value of the interrupt pin synchroniser, its idle high level
`define PDC_NMI_RST 1'b1
// clock frequency limit for external wake-up from either source, in MHz
`define PDC_WAKE_LIMIT_MHZ 55
// core clock rate, in MHz
`define PDC_CLK_MHZ 20

`endif

// ===== logic/pdc_pkg.sv
package pdc_pkg;
  // power state, one-hot
  typedef enum logic [1:0] {
    PDC_RUN = 2'b01,
    PDC_DOWN = 2'b10
  } pdc_state_e;
endpackage

// ===== logic/pdc_power_down_entry_control.sv
`include "pdc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pdc_power_down_entry_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_down_instruction,
  input wire logic wake_source_config_bit,
  input wire logic [`PDC_P2_W-1:0] p2_wake_enable,
  input wire logic [`PDC_P2_W-1:0] p2_active_high,
  input wire logic [`PDC_P2_W-1:0] p2_pin,
  input wire logic nmi_pin,
  input wire logic [7:0] cpu_clk_mhz,
  output logic power_down,
  output logic pd_ignored,
  output logic wake_event,
  output logic wake_unsupported
);

  // two-flop synchronisers for the external pins
  logic [`PDC_P2_W-1:0] p2_meta;
  logic [`PDC_P2_W-1:0] p2_sync;
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_sync_d;
  // power state and its next value
  pdc_pkg::pdc_state_e state;
  pdc_pkg::pdc_state_e next_state;
  // wake-source qualification terms
  logic [`PDC_P2_W-1:0] p2_hit;
  logic p2_any_active;
  logic entry_blocked;
  logic take_entry;
  logic refuse_entry;
  logic nmi_fall;
  logic over_limit;

  // port 2 pins into the clock domain, low at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p2_meta <= '0;
      p2_sync <= '0;
    end else begin
      p2_meta <= p2_pin;
      p2_sync <= p2_meta;
    end
  end

  // interrupt pin into the clock domain, reset to its idle high level
  // so a pin held high across reset blocks entry from the first edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_meta <= `PDC_NMI_RST;
      nmi_sync <= `PDC_NMI_RST;
    end else begin
      nmi_meta <= nmi_pin;
      nmi_sync <= nmi_meta;
    end
  end

  // delayed copy for the falling-edge detector, fed by the second flop only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_sync_d <= `PDC_NMI_RST;
    end else begin
      nmi_sync_d <= nmi_sync;
    end
  end

  // per-pin wake qualification: enabled and at its active level
  genvar gi;
  generate
    for (gi = 0; gi < `PDC_P2_W; gi++) begin : g_p2_hit
      assign p2_hit[gi] = p2_wake_enable[gi] && (p2_sync[gi] == p2_active_high[gi]);
    end
  endgenerate

  // entry decision from the selected wake source
  assign p2_any_active = |p2_hit;
  assign entry_blocked = wake_source_config_bit ? p2_any_active
                                                : nmi_sync;
  assign take_entry = power_down_instruction && (state == pdc_pkg::PDC_RUN)
                      && !entry_blocked;
  assign refuse_entry = power_down_instruction && (state == pdc_pkg::PDC_RUN)
                        && entry_blocked;
  assign nmi_fall = nmi_sync_d && !nmi_sync;
  assign over_limit = cpu_clk_mhz > 8'(`PDC_WAKE_LIMIT_MHZ);

  // power state transitions; reset (nrst) always exits at any clock rate
  always_comb begin
    next_state = state;
    case (state)
      // run: a clean request enters power-down
      pdc_pkg::PDC_RUN: begin
        if (take_entry) begin
          next_state = pdc_pkg::PDC_DOWN;
        end
      end
      // down: leave on a wake from the selected source
      pdc_pkg::PDC_DOWN: begin
        if (wake_event) begin
          next_state = pdc_pkg::PDC_RUN;
        end
      end
      // illegal code falls back to run
      default: begin
        next_state = pdc_pkg::PDC_RUN;
      end
    endcase
  end

  // state register, reset exit is unconditional
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= pdc_pkg::PDC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // external wake from power-down
  assign wake_event = (state == pdc_pkg::PDC_DOWN) &&
                      (wake_source_config_bit ? p2_any_active : nmi_fall);
  assign power_down = (state == pdc_pkg::PDC_DOWN);

  // flag a wake at a clock above the supported limit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_unsupported <= 1'b0;
    end else begin
      wake_unsupported <= wake_event && over_limit;
    end
  end

  // one-cycle pulse for a refused request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_ignored <= 1'b0;
    end else begin
      pd_ignored <= refuse_entry;
    end
  end

  // interrupt pin high refuses entry
  chk_nmi_blocks: assert property (@(posedge clk) disable iff (!nrst)
    (power_down_instruction && !wake_source_config_bit && nmi_sync && !power_down)
    |=> !power_down && pd_ignored)
    else $error("entry taken with interrupt pin high");

  // active enabled wake pin refuses entry
  chk_p2_blocks: assert property (@(posedge clk) disable iff (!nrst)
    (power_down_instruction && wake_source_config_bit && p2_any_active && !power_down)
    |=> !power_down && pd_ignored)
    else $error("entry taken with wake pin active");

  // clean request enters power-down
  chk_entry_taken: assert property (@(posedge clk) disable iff (!nrst)
    (power_down_instruction && !power_down &&
     (wake_source_config_bit ? !p2_any_active : !nmi_sync))
    |=> power_down && !pd_ignored)
    else $error("clean entry not taken");

  // power-down only follows a request
  chk_no_spont_down: assert property (@(posedge clk) disable iff (!nrst)
    $rose(power_down) |-> $past(power_down_instruction))
    else $error("power-down without request");

  // limit flag follows the clock rate at the wake
  chk_wake_limit: assert property (@(posedge clk) disable iff (!nrst)
    wake_event |=> (wake_unsupported == ($past(cpu_clk_mhz) > 8'(`PDC_WAKE_LIMIT_MHZ))))
    else $error("wake limit flag wrong");

  // power-down holds until a wake
  chk_down_holds: assert property (@(posedge clk) disable iff (!nrst)
    (power_down && !wake_event)
    |=> power_down)
    else $error("power-down left without wake");

  // a wake always returns to run
  chk_wake_exit: assert property (@(posedge clk) disable iff (!nrst)
    wake_event
    |=> !power_down)
    else $error("wake did not leave power-down");

  // interrupt falling edge wakes under the interrupt source
  chk_nmi_wake: assert property (@(posedge clk) disable iff (!nrst)
    (power_down && !wake_source_config_bit && nmi_sync_d && !nmi_sync)
    |-> wake_event)
    else $error("interrupt edge did not wake");

  // active enabled pin wakes under the port source
  chk_port_wake: assert property (@(posedge clk) disable iff (!nrst)
    (power_down && wake_source_config_bit && p2_any_active)
    |-> wake_event)
    else $error("wake pin did not wake");

  // a refused request never shows power-down
  chk_ignore_excl: assert property (@(posedge clk) disable iff (!nrst)
    pd_ignored
    |-> !power_down)
    else $error("refused request entered power-down");

  // state code stays one-hot
  chk_state_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot(state))
    else $error("power state code not one-hot");

  // limit flag only follows a wake
  chk_unsup_pulse: assert property (@(posedge clk) disable iff (!nrst)
    wake_unsupported
    |-> $past(wake_event))
    else $error("limit flag without wake");

endmodule

`default_nettype wire

// ===== sim/pdc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// wake pins and interrupt line
module pdc_far_side (
  input wire logic nmi_lvl,
  input wire logic [15:0] p2_lvl,
  output logic nmi_pin,
  output logic [15:0] p2_pin
);
  // pins always driven by the board
  assign nmi_pin = nmi_lvl;
  assign p2_pin = p2_lvl;
endmodule
`default_nettype wire

// ===== sim/power_down_entry_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_down_entry_control_tb;
  logic clk = 0, nrst = 0, ins = 0, cfg = 0, nl = 1, nmi, pd, ign, wk, wku;
  logic [15:0] en = 16'h0001, ah = 16'h0001, pl = 16'h0000, p2;
  logic [7:0] mhz = 8'h14;
  int miscompares = 0, checks = 0, cyc = 0;
  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      miscompares++;
      give_verdict;
    end
  end
  pdc_far_side FAR (.nmi_lvl(nl), .p2_lvl(pl), .nmi_pin(nmi), .p2_pin(p2));
  pdc_power_down_entry_control DUT (.clk(clk), .nrst(nrst), .power_down_instruction(ins),
    .wake_source_config_bit(cfg), .p2_wake_enable(en), .p2_active_high(ah), .p2_pin(p2),
    .nmi_pin(nmi), .cpu_clk_mhz(mhz), .power_down(pd), .pd_ignored(ign),
    .wake_event(wk), .wake_unsupported(wku));
  task chk(input logic s, input logic e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %b", $time, s);
    end
  endtask
  task give_verdict;
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one request after stable pins, judge answer
  task req(input logic e);
    repeat (3) @(negedge clk);
    ins = 1;
    @(negedge clk);
    ins = 0;
    chk(pd, e);
    chk(ign, !e);
  endtask
  // interrupt pin source, wake above the limit
  task t_nmi;
    req(0);
    nl = 0;
    req(1);
    mhz = 8'h38;
    nl = 1;
    repeat (3) @(negedge clk);
    nl = 0;
    repeat (2) @(negedge clk);
    chk(wk, 1);
    @(negedge clk);
    chk(pd, 0);
    chk(wku, 1);
  endtask
  // port source, wake at the limit
  task t_port;
    cfg = 1;
    mhz = 8'h37;
    pl = 16'h0001;
    req(0);
    pl = 16'h0002;
    req(1);
    pl = 16'h0001;
    repeat (3) @(negedge clk);
    chk(pd, 0);
    chk(wku, 0);
    ah = 16'h0000;
    pl = 16'h0000;
    req(0);
    pl = 16'h0001;
    req(1);
    pl = 16'h0000;
    repeat (3) @(negedge clk);
    chk(pd, 0);
    ah = 16'h0001;
  endtask
  // reset wake at a high clock
  task t_rst;
    pl = 16'h0000;
    mhz = 8'h40;
    req(1);
    nrst = 0;
    @(negedge clk);
    chk(pd, 0);
    nrst = 1;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1;
    t_nmi;
    t_port;
    t_rst;
    give_verdict;
  end
endmodule
`default_nettype wire
